// ==== shared/t2c_cfg.svh ====
/*
  Register addresses, control bit positions and prescaler counts of the
  timer 2 block. Assumes the includer is a design file of that block.
*/
`ifndef T2C_CFG_SVH
`define T2C_CFG_SVH

// Special function register addresses
`define T2C_ADDR_CTRL     8'hc8
`define T2C_ADDR_RLD_LO   8'hca
`define T2C_ADDR_RLD_HI   8'hcb
`define T2C_ADDR_CNT_LO   8'hcc
`define T2C_ADDR_CNT_HI   8'hcd

// Control register bit positions
`define T2C_B_HI_FLAG     7
`define T2C_B_LO_FLAG     6
`define T2C_B_LO_IRQ_EN   5
`define T2C_B_CAP_EN      4
`define T2C_B_SPLIT       3
`define T2C_B_RUN         2
`define T2C_B_UNUSED      1
`define T2C_B_XCLK        0

// Reset values and masks
`define T2C_CTRL_RESET    8'h00
`define T2C_BYTE_RESET    8'h00
`define T2C_BYTE_MAX      8'hff
`define T2C_CTRL_WMASK    8'hfd

// Prescalers: system clock by 12, external oscillator by 8
`define T2C_DIV12_LAST    4'hb
`define T2C_EXT8_LAST     3'h7
`endif

// ==== shared/t2c_clk_if.sv ====
/*
  Tick strobes from the prescaler module to the timer core.
  Assumes both ends run on core_clk.
*/
interface t2c_clk_if;
  logic sys12_tick; // One pulse per 12 system clocks
  logic ext8_tick;  // One pulse per 8 external rising edges
  logic cap_evt;    // Falling edge of external clock by 8
  modport src  (output sys12_tick, output ext8_tick, output cap_evt);
  modport sink (input  sys12_tick, input  ext8_tick, input  cap_evt);
endinterface : t2c_clk_if

// ==== shared/t2c_pkg.sv ====
/*
  Types of the timer 2 block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package t2c_pkg;
  // One timer or reload byte
  typedef logic [7:0] t2c_byte_t;
  // Clock source of one counter byte
  typedef enum logic [1:0] {
    T2C_SRC_SYS12 = 2'b00,
    T2C_SRC_EXT8  = 2'b01,
    T2C_SRC_SYS   = 2'b11
  } t2c_src_e;
endpackage : t2c_pkg

// ==== verif/t2c_timer2_bench.sv ====
/*
  Self-checking bench of the timer 2 block: register calls with expected
  values. Assumes the design and t2c_monitor are compiled before it.
*/
module t2c_timer2_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       core_clk;   // 100 MHz clock
  logic       rst_n;      // Active low reset
  logic       ext_osc;    // Toggles each cycle, so one ext/8 tick per 16
  logic [7:0] sfr_addr;   // Register address
  logic [7:0] sfr_wdata;  // Write data
  logic       sfr_wr;     // Write strobe
  logic       sfr_rd;     // Read strobe
  logic       irq_en;     // Global timer interrupt enable
  logic       hi_sys;     // High byte on plain clock
  logic       lo_sys;     // Low byte on plain clock
  logic [7:0] sfr_rdata;  // Registered read data
  logic       timer2_irq; // Interrupt request
  int         fail_count; // Mismatches
  int         n_checks;   // Comparisons
  int         cycles;     // Hang guard
  int         per;        // Prescaler period under test
  t2c_timer2 u_dut (.core_clk(core_clk), .rst_n(rst_n), .ext_osc(ext_osc),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .timer_irq_enable(irq_en), .high_byte_system_clock_select(hi_sys),
    .low_byte_system_clock_select(lo_sys), .sfr_rdata(sfr_rdata), .timer2_irq(timer2_irq));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Free running oscillator, parked low in reset; also counts the hang guard
  always @(posedge core_clk) begin
    if (!rst_n) begin
      ext_osc <= 1'b0;
      cycles  <= 0;
    end else begin
      ext_osc <= ~ext_osc;
      cycles  <= cycles + 1;
    end
  end
  task automatic close_out();
    if (fail_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One write strobe; a gap cycle follows so strobes never merge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge core_clk);
    sfr_wr    <= 1'b0;
  endtask : wr
  // Read data lands one cycle after the strobe edge
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    @(posedge core_clk);
    sfr_rd   <= 1'b0;
    #1 chk(sfr_rdata, exp);
  endtask : rd
  initial begin
    rst_n = 1'b0; sfr_addr = 8'h00; sfr_wdata = 8'h00;
    sfr_wr = 1'b0; sfr_rd = 1'b0; irq_en = 1'b0; hi_sys = 1'b1; lo_sys = 1'b1;
    fail_count = 0; n_checks = 0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    // Hang guard: a run that outlives its budget counts as a mismatch
    fork
      begin
        wait (cycles >= 2000);
        fail_count++;
        close_out();
      end
    join_none
    // Reset values, unmapped 0xc9 among them, then the control write mask
    for (int i = 0; i < 6; i++) begin
      rd(8'hc8 + 8'(i), 8'h00);
    end
    wr(8'hc8, 8'hff);
    rd(8'hc8, 8'hfd);
    wr(8'hc8, 8'h00);
    rd(8'hc8, 8'h00);
    // 16-bit wrap: flags, reload, request
    @(posedge core_clk);
    irq_en <= 1'b1;
    wr(8'hca, 8'h34);
    wr(8'hcb, 8'h12);
    wr(8'hcd, 8'hff);
    wr(8'hcc, 8'hff);
    wr(8'hc8, 8'h04);
    rd(8'hc8, 8'hc4);
    chk({7'h00, timer2_irq}, 8'h01);
    wr(8'hc8, 8'hc0);
    rd(8'hcd, 8'h12);
    wr(8'hc8, 8'h00);
    repeat (2) @(posedge core_clk);
    #1 chk({7'h00, timer2_irq}, 8'h00);
    // Split mode: low byte runs with run bit off
    wr(8'hcc, 8'hff);
    wr(8'hcd, 8'hff);
    wr(8'hca, 8'h55);
    wr(8'hcb, 8'h66);
    wr(8'hc8, 8'h08);
    rd(8'hc8, 8'h48);
    rd(8'hcd, 8'hff);
    chk({7'h00, timer2_irq}, 8'h00);
    wr(8'hc8, 8'h68);
    rd(8'hc8, 8'h68);
    chk({7'h00, timer2_irq}, 8'h01);
    wr(8'hcc, 8'h00);
    wr(8'hc8, 8'h0c);
    rd(8'hc8, 8'h8c);
    // Prescalers in split mode: both bytes count ten periods of system_clock/12,
    // then of ext/8, so the shared external select is seen on both bytes
    wr(8'hc8, 8'h00);
    hi_sys <= 1'b0;
    lo_sys <= 1'b0;
    for (int m = 0; m < 2; m++) begin
      per = (m == 1) ? 16 : 12;
      wr(8'hcc, 8'h00);
      wr(8'hcd, 8'h00);
      wr(8'hc8, 8'h0c | 8'(m));
      repeat (per * 10 - 2) @(posedge core_clk);
      wr(8'hc8, 8'(m));
      rd(8'hcc, 8'h0a);
      rd(8'hcd, 8'h0a);
    end
    rd(8'hcb, 8'h66);
    // Capture of a held count
    wr(8'hcd, 8'h3c);
    wr(8'hcc, 8'h5a);
    wr(8'hc8, 8'h10);
    repeat (20) @(posedge core_clk);
    rd(8'hcb, 8'h3c);
    rd(8'hca, 8'h5a);
    rd(8'hc8, 8'h90);
    close_out();
  end
endmodule : t2c_timer2_bench

bind t2c_timer2 t2c_monitor u_mon (.core_clk(core_clk), .rst_n(rst_n),
  .ext_osc(ext_osc), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
  .sfr_rd(sfr_rd), .timer_irq_enable(timer_irq_enable),
  .high_byte_system_clock_select(high_byte_system_clock_select),
  .low_byte_system_clock_select(low_byte_system_clock_select), .sfr_rdata(sfr_rdata),
  .timer2_irq(timer2_irq));

// ==== verif/t2c_timer2_monitor.sv ====
/*
  Port checker of the timer 2 block.
  Assumes it is bound to t2c_timer2 and sees only its ports, one clock.
*/
module t2c_monitor (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       ext_osc,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic       timer_irq_enable,
  input wire logic       high_byte_system_clock_select,
  input wire logic       low_byte_system_clock_select,
  input wire logic [7:0] sfr_rdata,
  input wire logic       timer2_irq
);
  // All checks share the core clock and its reset
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Read data stands one cycle only
  AST_RD_IDLE: assert property (!sfr_rd |=> sfr_rdata == 8'h00)
    else $error("read data not zero without a read");
  AST_BIT1_ZERO: assert property (sfr_rd && sfr_addr == 8'hc8 |=> !sfr_rdata[1])
    else $error("control bit 1 read as one");
  AST_UNMAPPED: assert property (sfr_rd && sfr_addr == 8'hc9 |=> sfr_rdata == 8'h00)
    else $error("unmapped address returned data");
  // Control bits written are read back, flag bits 7 and 6 and bit 1 excluded
  AST_CTRL_RB: assert property ((sfr_wr && sfr_addr == 8'hc8) ##1 !sfr_wr ##1
    (sfr_rd && !sfr_wr && sfr_addr == 8'hc8)
    |=> (sfr_rdata & 8'h3d) == ($past(sfr_wdata, 3) & 8'h3d))
    else $error("control readback differs from write");
  AST_IRQ_GATE: assert property (timer2_irq |-> $past(timer_irq_enable))
    else $error("request without global enable");
  // Flags never fall by themselves, so the request holds without writes
  // A write one cycle back may already have cleared the flags, so skip it
  AST_IRQ_HOLD: assert property (timer2_irq && timer_irq_enable && !sfr_wr
    && !$past(sfr_wr) |=> timer2_irq)
    else $error("request dropped without software");
  AST_HI_IRQ: assert property ((sfr_rd && sfr_addr == 8'hc8 && timer_irq_enable)
    ##1 sfr_rdata[7] |-> timer2_irq)
    else $error("high flag set but no request");
  AST_LO_IRQ: assert property ((sfr_rd && sfr_addr == 8'hc8 && timer_irq_enable)
    ##1 (sfr_rdata[6] && sfr_rdata[5]) |-> timer2_irq)
    else $error("enabled low flag set but no request");
  AST_NO_IRQ: assert property ((sfr_rd && !sfr_wr && sfr_addr == 8'hc8)
    ##1 (!sfr_rdata[7] && !(sfr_rdata[6] && sfr_rdata[5])) |-> !timer2_irq)
    else $error("request without qualified flag");
endmodule : t2c_monitor

// ==== verilog/t2c_clk_src.sv ====
/*
  Prescalers of timer 2: system clock by 12 and external oscillator by 8,
  plus the capture event. Assumes ext_osc already synchronous to core_clk.
*/
`include "t2c_cfg.svh"
module t2c_clk_src (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic ext_osc,
  t2c_clk_if.src    tk
);
  logic [3:0] div12_r; // System clock divider count
  logic [2:0] div8_r;  // External edge count, bit 2 is the divided clock
  logic       osc_r;   // Previous oscillator sample
  logic       osc_rise;

  assign osc_rise = ext_osc && !osc_r;

  // Divide the system clock by 12
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div12_r       <= 4'h0;
      tk.sys12_tick <= 1'b0;
    end else begin
      tk.sys12_tick <= (div12_r == `T2C_DIV12_LAST);
      if (div12_r == `T2C_DIV12_LAST) begin
        div12_r <= 4'h0;
      end else begin
        div12_r <= div12_r + 4'h1;
      end
    end
  end

  // Divide the external oscillator by 8; the divided clock falls on wrap
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_r        <= 1'b0;
      div8_r       <= 3'h0;
      tk.ext8_tick <= 1'b0;
      tk.cap_evt   <= 1'b0;
    end else begin
      osc_r        <= ext_osc;
      tk.ext8_tick <= osc_rise && (div8_r == `T2C_EXT8_LAST);
      tk.cap_evt   <= osc_rise && (div8_r == `T2C_EXT8_LAST);
      if (osc_rise) begin
        div8_r <= div8_r + 3'h1;
      end
    end
  end
endmodule : t2c_clk_src

// ==== verilog/t2c_timer2.sv ====
/*
  Timer 2 core: control register, 16-bit or split 8-bit auto-reload
  counters, capture of the external oscillator and the interrupt request.
  Assumes a synchronous SFR port: one-cycle write and read strobes with an
  address, read data returned one clock later. The global timer interrupt
  enable and the per-byte clock selects come from other registers.
*/
`include "t2c_cfg.svh"
module t2c_timer2 (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       ext_osc,
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic       timer_irq_enable,
  input  wire logic       high_byte_system_clock_select,
  input  wire logic       low_byte_system_clock_select,
  output logic      [7:0] sfr_rdata,
  output logic            timer2_irq
);
  t2c_clk_if tk_if ();                      // Prescaler ticks

  t2c_pkg::t2c_byte_t timer2_control_reg_r; // Control and flags
  t2c_pkg::t2c_byte_t timer2_control_nxt;   // Next control value
  t2c_pkg::t2c_byte_t counter_low_byte_r;   // Low counter byte
  t2c_pkg::t2c_byte_t counter_high_byte_r;  // High counter byte
  t2c_pkg::t2c_byte_t reload_low_byte_r;    // Low reload byte
  t2c_pkg::t2c_byte_t reload_high_byte_r;   // High reload byte
  t2c_pkg::t2c_src_e  src_lo;               // Low byte clock source
  t2c_pkg::t2c_src_e  src_hi;               // High byte clock source

  logic wr_ctrl, wr_rld_lo, wr_rld_hi;      // Register write decodes
  logic wr_cnt_lo, wr_cnt_hi;
  logic tick_lo, tick_hi;                   // Selected clock ticks
  logic inc_lo, inc_hi;                     // Counter increments
  logic ovf_lo, ovf_hi;                     // Byte overflows at 0xff
  logic reload_lo;                          // Low byte reload
  logic cap_hit;                            // Capture in this cycle
  logic split_mode_select, run_control;     // Control fields
  logic capture_mode_enable, external_clock_select;
  logic low_byte_irq_enable;

  // Prescalers live in their own module
  t2c_clk_src u_clk_src (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .ext_osc  (ext_osc),
    .tk       (tk_if.src)
  );

  // Control fields
  assign split_mode_select     = timer2_control_reg_r[`T2C_B_SPLIT];
  assign run_control           = timer2_control_reg_r[`T2C_B_RUN];
  assign capture_mode_enable   = timer2_control_reg_r[`T2C_B_CAP_EN];
  assign external_clock_select = timer2_control_reg_r[`T2C_B_XCLK];
  assign low_byte_irq_enable   = timer2_control_reg_r[`T2C_B_LO_IRQ_EN];

  // Write decode
  always_comb begin
    wr_ctrl   = 1'b0;
    wr_rld_lo = 1'b0;
    wr_rld_hi = 1'b0;
    wr_cnt_lo = 1'b0;
    wr_cnt_hi = 1'b0;
    if (!sfr_wr) begin
      wr_ctrl = 1'b0;           // No write this cycle
    end else if (sfr_addr == `T2C_ADDR_CTRL) begin
      wr_ctrl = 1'b1;
    end else if (sfr_addr == `T2C_ADDR_RLD_LO) begin
      wr_rld_lo = 1'b1;
    end else if (sfr_addr == `T2C_ADDR_RLD_HI) begin
      wr_rld_hi = 1'b1;
    end else if (sfr_addr == `T2C_ADDR_CNT_LO) begin
      wr_cnt_lo = 1'b1;
    end else if (sfr_addr == `T2C_ADDR_CNT_HI) begin
      wr_cnt_hi = 1'b1;
    end
  end

  // Clock source per byte; one shared external select serves both bytes
  always_comb begin
    if (low_byte_system_clock_select) begin
      src_lo = t2c_pkg::T2C_SRC_SYS;
    end else if (external_clock_select) begin
      src_lo = t2c_pkg::T2C_SRC_EXT8;
    end else begin
      src_lo = t2c_pkg::T2C_SRC_SYS12;
    end
    if (high_byte_system_clock_select) begin
      src_hi = t2c_pkg::T2C_SRC_SYS;
    end else if (external_clock_select) begin
      src_hi = t2c_pkg::T2C_SRC_EXT8;
    end else begin
      src_hi = t2c_pkg::T2C_SRC_SYS12;
    end
  end

  // Turn each byte's source into a tick
  always_comb begin
    case (src_lo)
      t2c_pkg::T2C_SRC_SYS:  tick_lo = 1'b1;
      t2c_pkg::T2C_SRC_EXT8: tick_lo = tk_if.ext8_tick;
      default:               tick_lo = tk_if.sys12_tick;
    endcase
    case (src_hi)
      t2c_pkg::T2C_SRC_SYS:  tick_hi = 1'b1;
      t2c_pkg::T2C_SRC_EXT8: tick_hi = tk_if.ext8_tick;
      default:               tick_hi = tk_if.sys12_tick;
    endcase
  end

  // Increment and wrap terms. In 16-bit mode the high byte moves only on
  // the low byte's carry, so its wrap is the full 0xffff wrap.
  always_comb begin
    if (split_mode_select) begin
      inc_lo = tick_lo;
      inc_hi = run_control && tick_hi;
    end else begin
      inc_lo = run_control && tick_lo;
      inc_hi = 1'b0;
    end
    ovf_lo = inc_lo && (counter_low_byte_r == `T2C_BYTE_MAX);
    if (!split_mode_select) begin
      inc_hi = ovf_lo;
    end
    ovf_hi    = inc_hi && (counter_high_byte_r == `T2C_BYTE_MAX);
    reload_lo = split_mode_select ? ovf_lo : ovf_hi;
  end

  // Capture only counts in capture mode
  assign cap_hit = capture_mode_enable && tk_if.cap_evt;

  // Low counter byte; a software write wins over counting
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      counter_low_byte_r <= `T2C_BYTE_RESET;
    end else if (wr_cnt_lo) begin
      counter_low_byte_r <= sfr_wdata;
    end else if (reload_lo) begin
      counter_low_byte_r <= reload_low_byte_r;
    end else if (inc_lo) begin
      counter_low_byte_r <= counter_low_byte_r + 8'h01;
    end
  end

  // High counter byte
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      counter_high_byte_r <= `T2C_BYTE_RESET;
    end else if (wr_cnt_hi) begin
      counter_high_byte_r <= sfr_wdata;
    end else if (ovf_hi) begin
      counter_high_byte_r <= reload_high_byte_r;
    end else if (inc_hi) begin
      counter_high_byte_r <= counter_high_byte_r + 8'h01;
    end
  end

  // Reload bytes; capture copies the live count, a write wins over it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reload_low_byte_r  <= `T2C_BYTE_RESET;
      reload_high_byte_r <= `T2C_BYTE_RESET;
    end else begin
      if (wr_rld_lo) begin
        reload_low_byte_r <= sfr_wdata;
      end else if (cap_hit) begin
        reload_low_byte_r <= counter_low_byte_r;
      end
      if (wr_rld_hi) begin
        reload_high_byte_r <= sfr_wdata;
      end else if (cap_hit) begin
        reload_high_byte_r <= counter_high_byte_r;
      end
    end
  end

  // Next control value. A hardware set lands after the software write so
  // that an overflow in the clearing cycle is never lost.
  always_comb begin
    timer2_control_nxt = timer2_control_reg_r;
    if (wr_ctrl) begin
      timer2_control_nxt = sfr_wdata & `T2C_CTRL_WMASK;
    end
    if (ovf_hi || cap_hit) begin
      timer2_control_nxt[`T2C_B_HI_FLAG] = 1'b1;
    end
    if (ovf_lo) begin
      timer2_control_nxt[`T2C_B_LO_FLAG] = 1'b1;
    end
  end

  // Control register; flags never clear without software
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer2_control_reg_r <= `T2C_CTRL_RESET;
    end else begin
      timer2_control_reg_r <= timer2_control_nxt;
    end
  end

  // Interrupt request, registered, one cycle behind the flags
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer2_irq <= 1'b0;
    end else begin
      timer2_irq <= timer_irq_enable &&
                    (timer2_control_reg_r[`T2C_B_HI_FLAG] ||
                     (low_byte_irq_enable &&
                      timer2_control_reg_r[`T2C_B_LO_FLAG]));
    end
  end

  // Read data, registered; unmapped addresses read zero
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= 8'h00;
    end else if (!sfr_rd) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_addr == `T2C_ADDR_CTRL) begin
      sfr_rdata <= timer2_control_reg_r;
    end else if (sfr_addr == `T2C_ADDR_RLD_LO) begin
      sfr_rdata <= reload_low_byte_r;
    end else if (sfr_addr == `T2C_ADDR_RLD_HI) begin
      sfr_rdata <= reload_high_byte_r;
    end else if (sfr_addr == `T2C_ADDR_CNT_LO) begin
      sfr_rdata <= counter_low_byte_r;
    end else if (sfr_addr == `T2C_ADDR_CNT_HI) begin
      sfr_rdata <= counter_high_byte_r;
    end else begin
      sfr_rdata <= 8'h00;
    end
  end
endmodule : t2c_timer2
